// ==== src/cbg_pkg.sv ====
/*
  Constants, carriers and lane-mapping helpers for the core-to-AHB-Lite gasket.
  Assumes a single 50 MHz system clock and a synchronous active-high reset.
*/
package cbg_pkg;

  // ---------------------------------------------------------------------
  // register map (byte addresses on the APB)
  // ---------------------------------------------------------------------
  localparam int          APB_AW       = 8;
  localparam logic [7:0]  REG_CTRL     = 8'h00;
  localparam logic [7:0]  REG_STATUS   = 8'h04;
  localparam logic [7:0]  REG_CAUSE    = 8'h08;
  localparam logic [7:0]  REG_DFILL    = 8'h0c;
  localparam logic [7:0]  REG_IFILL    = 8'h10;
  localparam int          CAUSE_SHUT   = 0;
  localparam int          CAUSE_SGNT   = 1;
  localparam int          ST_SHUT_BIT  = 0;
  localparam int          ST_HALT_BIT  = 1;
  localparam int          ST_GATE_BIT  = 2;
  localparam logic [7:0]  HALT_DLY_RST = 8'h10;
  localparam logic [7:0]  HALT_DLY_MIN = 8'h07;
  localparam logic [31:0] FILL_RST     = 32'h0000_0000;

  // ---------------------------------------------------------------------
  // AHB-Lite encodings
  // ---------------------------------------------------------------------
  localparam logic [2:0] HSZ_BYTE      = 3'h0;
  localparam logic [2:0] HSZ_HALF      = 3'h1;
  localparam logic [2:0] HSZ_WORD      = 3'h2;
  localparam logic [1:0] HTR_IDLE      = 2'h0;
  localparam logic [1:0] HTR_NONSEQ    = 2'h2;
  localparam logic [2:0] HBURST_SINGLE = 3'h0;
  localparam logic [2:0] HPROT_UPPER   = 3'h0;

  typedef enum logic [2:0] {
    SPC_NONE, SPC_WBACK, SPC_FACK1, SPC_FACK2,
    SPC_FLUSH, SPC_SHUT, SPC_HALT, SPC_SGNT
  } cbg_spc_e;

  typedef struct packed {
    logic [31:0] addr;
    logic [3:0]  be;
    logic        write;
    logic        code;
    cbg_spc_e    spc;
    logic [31:0] wdata;
  } cbg_creq_s;

  typedef struct packed {
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [2:0]  hburst;
    logic [3:0]  hprot;
    logic [31:0] hwdata;
  } cbg_ahb_s;

  typedef struct packed {
    logic       ok;
    logic       two;
    logic [2:0] sz0;
    logic [1:0] lo0;
    logic [2:0] sz1;
    logic [1:0] lo1;
  } cbg_plan_s;

  localparam cbg_plan_s READ_PLAN = '{1'b1, 1'b0, HSZ_WORD, 2'h0, HSZ_WORD, 2'h0};

  // write enables to one or two legal single transfers
  function automatic cbg_plan_s cbg_plan(input logic [3:0] be);
    cbg_plan_s p;
    p = '0;
    case (be)
      4'h1: p = '{1'b1, 1'b0, HSZ_BYTE, 2'h0, HSZ_BYTE, 2'h0};
      4'h2: p = '{1'b1, 1'b0, HSZ_BYTE, 2'h1, HSZ_BYTE, 2'h0};
      4'h4: p = '{1'b1, 1'b0, HSZ_BYTE, 2'h2, HSZ_BYTE, 2'h0};
      4'h8: p = '{1'b1, 1'b0, HSZ_BYTE, 2'h3, HSZ_BYTE, 2'h0};
      4'h3: p = '{1'b1, 1'b0, HSZ_HALF, 2'h0, HSZ_BYTE, 2'h0};
      4'hc: p = '{1'b1, 1'b0, HSZ_HALF, 2'h2, HSZ_BYTE, 2'h0};
      4'hf: p = '{1'b1, 1'b0, HSZ_WORD, 2'h0, HSZ_BYTE, 2'h0};
      4'h6: p = '{1'b1, 1'b1, HSZ_BYTE, 2'h1, HSZ_BYTE, 2'h2};
      4'h7: p = '{1'b1, 1'b1, HSZ_HALF, 2'h0, HSZ_BYTE, 2'h2};
      4'he: p = '{1'b1, 1'b1, HSZ_BYTE, 2'h1, HSZ_HALF, 2'h2};
      default: p = '0;
    endcase
    return p;
  endfunction : cbg_plan

  // one single transfer; only memory cycles of the core ever take this path
  function automatic cbg_ahb_s cbg_xfer(input cbg_creq_s r, input logic [2:0] sz,
                                        input logic [1:0]  lo);
    cbg_ahb_s a;
    a.haddr  = {r.addr[31:2], lo};
    a.htrans = HTR_NONSEQ;
    a.hwrite = r.write;
    a.hsize  = sz;
    a.hburst = HBURST_SINGLE;
    a.hprot  = {HPROT_UPPER, ~r.code};
    a.hwdata = r.wdata;
    return a;
  endfunction : cbg_xfer

endpackage : cbg_pkg

// ==== src/cbg_halt_gate.sv ====
/*
  Delayed core clock gating after a halt cycle, undone by break events.
  Assumes the delay input is already clamped to the legal minimum by its owner.
*/
`timescale 1ns/1ns
`default_nettype none
module cbg_halt_gate
  import cbg_pkg::*;
#(
  parameter int DLY_W = 8
) (
  // clock and reset
  input  wire logic             clk_sys_in,
  input  wire logic             sys_rst_in,
  // control
  input  wire logic             halt_in,
  input  wire logic             brk_in,
  input  wire logic [DLY_W-1:0] dly_in,
  // gate
  output logic                  clk_en_out
);

  typedef struct packed {
    logic             armed;
    logic [DLY_W-1:0] cnt;
    logic             clk_en;
  } cbg_hg_s;

  cbg_hg_s q;
  cbg_hg_s n;

  // ---------------------------------------------------------------------
  // countdown
  // ---------------------------------------------------------------------
  always_comb begin
    n = q;
    if (brk_in) begin
      n.armed  = 1'b0;
      n.clk_en = 1'b1;
    end else if (halt_in) begin
      n.armed = 1'b1;
      n.cnt   = dly_in;
    end else if (q.armed) begin
      if (q.cnt <= DLY_W'(1)) begin
        n.armed  = 1'b0;
        n.clk_en = 1'b0;
      end else begin
        n.cnt = q.cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      q        <= '0;
      q.clk_en <= 1'b1;
    end else begin
      q <= n;
    end
  end

  assign clk_en_out = q.clk_en;

  // ---------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------
  property p_hold_six;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      (halt_in && !brk_in) ##1 (!brk_in)[*6] |-> clk_en_out;
  endproperty
  a_hold_six: assert property (p_hold_six) else $error("clock gated too soon");

  property p_gate_at_min;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      (halt_in && !brk_in && dly_in == DLY_W'(HALT_DLY_MIN)) ##1 (!brk_in)[*7]
        |=> !clk_en_out;
  endproperty
  a_gate_at_min: assert property (p_gate_at_min) else $error("clock not gated");

  property p_brk_runs;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      brk_in |=> clk_en_out;
  endproperty
  a_brk_runs: assert property (p_brk_runs) else $error("gated with break");

endmodule : cbg_halt_gate
`default_nettype wire

// ==== src/cbg_gasket.sv ====
/*
  Gasket from the core front-side bus to AHB-Lite, with special-cycle
  handling, halt clock gating and an APB register slave.
  Assumes the core holds a request until acknowledged, drops it for at least
  one cycle afterwards, and that the fabric decoder judges the request address.
*/
`timescale 1ns/1ns
`default_nettype none
module cbg_gasket
  import cbg_pkg::*;
#(
  parameter int DLY_W = 8
) (
  // clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        sys_rst_in,
  // core front-side bus
  input  wire logic        cpu_req_in,
  input  wire cbg_creq_s   cpu_bus_in,
  output logic             cpu_ack_out,
  output logic             cpu_err_out,
  output logic [31:0]      cpu_rdata_out,
  // break sources
  input  wire logic        irq_pend_in,
  input  wire logic        probe_req_in,
  // AHB-Lite master
  output var cbg_ahb_s     ahb_out,
  input  wire logic        hready_in,
  input  wire logic        hresp_in,
  input  wire logic [31:0] hrdata_in,
  input  wire logic        map_hit_in,
  // APB slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic [31:0]      prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // system side
  output logic             shutdown_ind_out,
  output logic             warm_rst_req_out,
  output logic             halt_ind_out,
  output logic             stop_grant_ind_out,
  output logic             core_clk_en_out,
  output logic             stop_clock_request_n_out,
  output logic             nmi_out,
  output logic [31:0]      data_fill_out,
  output logic [31:0]      instr_fill_out
);

  // the reset delay needs five bits; anything narrower would reset to zero
  if (DLY_W < 5 || DLY_W > 32) begin : g_chk
    $error("DLY_W must hold the reset halt delay and fit a word");
  end

  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_DATA, ST_DEAD} cbg_st_e;

  typedef struct packed {
    cbg_st_e          st;
    cbg_creq_s        req;
    cbg_plan_s        plan;
    cbg_ahb_s         ahb;
    logic             part;
    logic             err;
    logic             ack;
    logic [31:0]      rdata;
    logic             shut_ind;
    logic             warm_rst;
    logic             halt_ind;
    logic             halt_go;
    logic             sg_ind;
    logic [1:0]       cause;
    logic [DLY_W-1:0] dly;
    logic [31:0]      dfill;
    logic [31:0]      ifill;
    logic             pready;
    logic             pslverr;
    logic [31:0]      prdata;
    logic             stop_req_n;
    logic             nmi;
  } cbg_top_s;

  cbg_top_s q;
  cbg_top_s n;
  logic     brk;
  logic     take;
  logic     clk_en;
  logic     apb_wr;

  // boundary-scan activity is deliberately absent from the break sources
  assign brk    = irq_pend_in | probe_req_in;
  assign take   = (q.st == ST_IDLE) && cpu_req_in && !q.ack;
  assign apb_wr = psel_in && penable_in && q.pready && pwrite_in;

  // ---------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------
  always_comb begin
    n          = q;
    n.ack      = 1'b0;
    n.warm_rst = 1'b0;
    n.halt_go  = 1'b0;
    n.sg_ind   = 1'b0;
    n.pready   = 1'b0;
    n.pslverr  = 1'b0;

    // apb setup phase: answer is prepared here and shown in the access phase
    if (psel_in && !penable_in) begin
      n.pready = 1'b1;
      n.prdata = '0;
      case (paddr_in)
        REG_CTRL:   n.prdata = 32'(q.dly);
        REG_STATUS: begin
          n.prdata[ST_SHUT_BIT] = q.shut_ind;
          n.prdata[ST_HALT_BIT] = q.halt_ind;
          n.prdata[ST_GATE_BIT] = ~clk_en;
        end
        REG_CAUSE:  n.prdata = 32'(q.cause);
        REG_DFILL:  n.prdata = q.dfill;
        REG_IFILL:  n.prdata = q.ifill;
        default:    n.pslverr = 1'b1;
      endcase
    end

    // apb access phase writes; cause bits clear before hardware may set them
    if (apb_wr) begin
      case (paddr_in)
        REG_CTRL: begin
          if (pwdata_in[DLY_W-1:0] < DLY_W'(HALT_DLY_MIN)) begin
            n.dly = DLY_W'(HALT_DLY_MIN);
          end else begin
            n.dly = pwdata_in[DLY_W-1:0];
          end
        end
        REG_CAUSE: n.cause = q.cause & ~pwdata_in[1:0];
        REG_DFILL: n.dfill = pwdata_in;
        REG_IFILL: n.ifill = pwdata_in;
        default: ;
      endcase
    end

    if (brk) begin
      n.halt_ind = 1'b0;
    end

    case (q.st)
      ST_IDLE: begin
        if (take) begin
          n.req  = cpu_bus_in;
          n.err  = 1'b0;
          n.part = 1'b0;
          // reads always go out as whole words
          n.plan = cpu_bus_in.write ? cbg_plan(cpu_bus_in.be) : READ_PLAN;
          case (cpu_bus_in.spc)
            SPC_WBACK: n.ack = 1'b1;
            SPC_FLUSH: n.ack = 1'b1;
            SPC_FACK1, SPC_FACK2: n.ack = 1'b1;
            SPC_SHUT: begin
              n.ack              = 1'b1;
              n.shut_ind         = 1'b1;
              n.warm_rst         = 1'b1;
              n.cause[CAUSE_SHUT] = 1'b1;
              n.st               = ST_DEAD;
            end
            SPC_HALT: begin
              n.ack      = 1'b1;
              n.halt_ind = 1'b1;
              n.halt_go  = 1'b1;
            end
            SPC_SGNT: begin
              n.ack               = 1'b1;
              n.sg_ind            = 1'b1;
              n.cause[CAUSE_SGNT] = 1'b1;
            end
            default: begin
              if (!map_hit_in) begin
                // unmapped: complete at once, reads give zero
                n.ack   = 1'b1;
                n.rdata = '0;
              end else if (!n.plan.ok) begin
                n.ack = 1'b1;
                n.err = 1'b1;
              end else begin
                // memory cycles only: no message or end-of-interrupt traffic
                n.ahb = cbg_xfer(cpu_bus_in, n.plan.sz0, n.plan.lo0);
                n.st  = ST_ADDR;
              end
            end
          endcase
        end
      end
      ST_ADDR: begin
        if (hready_in) begin
          n.ahb.htrans = HTR_IDLE;
          n.st         = ST_DATA;
        end
      end
      ST_DATA: begin
        if (hready_in) begin
          n.err   = q.err | hresp_in;
          n.rdata = hrdata_in;
          if (q.plan.two && !q.part) begin
            n.part = 1'b1;
            n.ahb  = cbg_xfer(q.req, q.plan.sz1, q.plan.lo1);
            n.st   = ST_ADDR;
          end else begin
            n.ack = 1'b1;
            n.st  = ST_IDLE;
          end
        end
      end
      // shutdown: nothing more is taken until reset
      ST_DEAD: n.st = ST_DEAD;
      default: n.st = ST_IDLE;
    endcase
  end

  // ---------------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      q          <= '0;
      q.dly      <= DLY_W'(HALT_DLY_RST);
      q.dfill    <= FILL_RST;
      q.ifill    <= FILL_RST;
      q.stop_req_n <= 1'b1;
      q.nmi      <= 1'b0;
    end else begin
      q <= n;
    end
  end

  // ---------------------------------------------------------------------
  // halt clock gate
  // ---------------------------------------------------------------------
  cbg_halt_gate #(
    .DLY_W      (DLY_W)
  ) u_halt_gate (
    .clk_sys_in (clk_sys_in),
    .sys_rst_in (sys_rst_in),
    .halt_in    (q.halt_go),
    .brk_in     (brk),
    .dly_in     (q.dly),
    .clk_en_out (clk_en)
  );

  // ---------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------
  assign cpu_ack_out              = q.ack;
  assign cpu_err_out              = q.err;
  assign cpu_rdata_out            = q.rdata;
  assign ahb_out                  = q.ahb;
  assign prdata_out               = q.prdata;
  assign pready_out               = q.pready;
  assign pslverr_out              = q.pslverr;
  assign shutdown_ind_out         = q.shut_ind;
  assign warm_rst_req_out         = q.warm_rst;
  assign halt_ind_out             = q.halt_ind;
  assign stop_grant_ind_out       = q.sg_ind;
  assign core_clk_en_out          = clk_en;
  assign stop_clock_request_n_out = q.stop_req_n;
  assign nmi_out                  = q.nmi;
  assign data_fill_out            = q.dfill;
  assign instr_fill_out           = q.ifill;

  // ---------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------
  property p_absorb;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      take && (cpu_bus_in.spc inside {SPC_WBACK, SPC_FLUSH, SPC_FACK1, SPC_FACK2})
        |=> cpu_ack_out && ahb_out.htrans == HTR_IDLE ##1 ahb_out.htrans == HTR_IDLE;
  endproperty
  a_absorb: assert property (p_absorb) else $error("special cycle leaked");

  property p_shut;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      take && cpu_bus_in.spc == SPC_SHUT
        |=> cpu_ack_out && shutdown_ind_out && warm_rst_req_out && q.cause[CAUSE_SHUT];
  endproperty
  a_shut: assert property (p_shut) else $error("shutdown not handled");

  property p_dead;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      shutdown_ind_out && $past(shutdown_ind_out) |-> !cpu_ack_out && q.st == ST_DEAD;
  endproperty
  a_dead: assert property (p_dead) else $error("core resumed after shutdown");

  property p_halt;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      take && cpu_bus_in.spc == SPC_HALT && !brk |=> cpu_ack_out && halt_ind_out;
  endproperty
  a_halt: assert property (p_halt) else $error("halt not flagged");

  property p_single;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      ahb_out.htrans == HTR_NONSEQ |-> ahb_out.hburst == HBURST_SINGLE;
  endproperty
  a_single: assert property (p_single) else $error("burst issued");

  property p_read_word;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      ahb_out.htrans == HTR_NONSEQ && !ahb_out.hwrite
        |-> ahb_out.hsize == HSZ_WORD && ahb_out.haddr[1:0] == 2'h0;
  endproperty
  a_read_word: assert property (p_read_word) else $error("read not a word");

  property p_prot;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      ahb_out.htrans == HTR_NONSEQ |-> ahb_out.hprot[0] == !q.req.code;
  endproperty
  a_prot: assert property (p_prot) else $error("bad protection bit");

  property p_split;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      take && cpu_bus_in.spc == SPC_NONE && map_hit_in && cpu_bus_in.write
        && cpu_bus_in.be == 4'h7
        |=> ahb_out.htrans == HTR_NONSEQ && ahb_out.hsize == HSZ_HALF
            && ahb_out.haddr[1:0] == 2'h0 && !cpu_ack_out;
  endproperty
  a_split: assert property (p_split) else $error("split first part wrong");

  property p_unmapped;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      take && cpu_bus_in.spc == SPC_NONE && !map_hit_in
        |=> cpu_ack_out && cpu_rdata_out == 32'h0 && ahb_out.htrans == HTR_IDLE;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped not closed");

  property p_bad_be;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      take && cpu_bus_in.spc == SPC_NONE && map_hit_in && cpu_bus_in.write
        && (cpu_bus_in.be inside {4'h0, 4'h5, 4'h9, 4'ha, 4'hb, 4'hd})
        |=> cpu_ack_out && cpu_err_out && ahb_out.htrans == HTR_IDLE;
  endproperty
  a_bad_be: assert property (p_bad_be) else $error("bad enables not refused");

  property p_static;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      stop_clock_request_n_out && !nmi_out;
  endproperty
  a_static: assert property (p_static) else $error("stop-clock or nmi raised");

endmodule : cbg_gasket
`default_nettype wire

// ==== verification/cbg_ahb_slave.sv ====
/* AHB-Lite slave model for the gasket bench: optional wait state and error.
   Assumes the bench's clock and reset; read data is the address scrambled. */
`timescale 1ns/1ns
`default_nettype none
module cbg_ahb_slave
  import cbg_pkg::*;
(
  // clock and reset
  input  wire logic     clk_sys_in,
  input  wire logic     sys_rst_in,
  // bench control
  input  wire logic     slow_in,
  input  wire logic     err_in,
  // fabric
  input  wire cbg_ahb_s ahb_in,
  output logic          hready_out,
  output logic          hresp_out,
  output logic [31:0]   hrdata_out,
  // observation
  output logic [31:0]   count_out,
  output logic [11:0]   log_out,
  output logic [31:0]   wdata_out,
  output logic          burst_out
);
  logic        dph;
  logic        wt;
  logic [31:0] a;
  assign hready_out = !(dph && wt);
  assign hresp_out  = dph && err_in;
  // off the data phase the bus shows the inverse, so stale data never matches
  assign hrdata_out = (dph && !wt) ? a ^ 32'h5a5a_a5a5 : ~(a ^ 32'h5a5a_a5a5);
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      {dph, wt, a, count_out, log_out, burst_out} <= '0;
    end else if (hready_out && ahb_in.htrans == HTR_NONSEQ) begin
      {dph, wt, a} <= {1'b1, slow_in, ahb_in.haddr};
      count_out <= count_out + 32'h1;
      log_out <= {log_out[5:0], ahb_in.hprot[0], ahb_in.hsize, ahb_in.haddr[1:0]};
      burst_out <= burst_out | (ahb_in.hburst != HBURST_SINGLE);
    end else if (dph) begin
      {dph, wt} <= {wt, 1'b0};
    end
  end
  // write data stands in the data phase, one cycle behind its address
  always_ff @(posedge clk_sys_in) begin
    if (dph && !wt) begin
      wdata_out <= ahb_in.hwdata;
    end
  end
endmodule : cbg_ahb_slave
`default_nettype wire

// ==== verification/cbg_gasket_tb.sv ====
/* Self-checking bench for the gasket: core requests, APB registers, events.
   Assumes the slave model answers the fabric side. */
`timescale 1ns/1ns
`default_nettype none
module cbg_gasket_tb
  import cbg_pkg::*;
();
  logic        clk, rst, req, irq, probe, hit, psel, pen, pwr, slow, err, e;
  logic        ack, cerr, hready, hresp, pready, pslverr, shut, warm, halt, sgnt;
  logic        cken, stpn, nmi, burst, ok, two, er, warm_seen, sg_seen;
  logic [7:0]  paddr;
  logic [11:0] lg;
  logic [31:0] rd, crd, hrdata, pwdata, prdata, dfill, ifill, cnt, c0, r, wd;
  cbg_creq_s   creq;
  cbg_ahb_s    ahb;
  int          bad_count, compares, n;
  cbg_spc_e    sp [5] = '{SPC_WBACK, SPC_FACK1, SPC_FACK2, SPC_FLUSH, SPC_SGNT};
  // enables, then expected {hprot0, hsize, lane} of first and second part
  logic [15:0] wtab [10] = '{16'h1020, 16'h2021, 16'h4022, 16'h8023, 16'h3024,
                             16'hc026, 16'hf028, 16'h6862, 16'h7922, 16'he866};

  cbg_gasket i_cbg_gasket (.clk_sys_in(clk), .sys_rst_in(rst), .cpu_req_in(req),
    .cpu_bus_in(creq), .cpu_ack_out(ack), .cpu_err_out(cerr), .cpu_rdata_out(crd),
    .irq_pend_in(irq), .probe_req_in(probe), .ahb_out(ahb), .hready_in(hready),
    .hresp_in(hresp), .hrdata_in(hrdata), .map_hit_in(hit), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .shutdown_ind_out(shut), .warm_rst_req_out(warm), .halt_ind_out(halt),
    .stop_grant_ind_out(sgnt), .core_clk_en_out(cken),
    .stop_clock_request_n_out(stpn), .nmi_out(nmi), .data_fill_out(dfill),
    .instr_fill_out(ifill));
  cbg_ahb_slave i_cbg_ahb_slave (.clk_sys_in(clk), .sys_rst_in(rst), .slow_in(slow),
    .err_in(err), .ahb_in(ahb), .hready_out(hready), .hresp_out(hresp),
    .hrdata_out(hrdata), .count_out(cnt), .log_out(lg), .wdata_out(wd), .burst_out(burst));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // pulses are too short for the tasks to see, so latch them
  always @(posedge clk) begin
    if (warm) warm_seen <= 1'b1;
    if (sgnt) sg_seen <= 1'b1;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    compares++;
    if (g !== x) begin
      bad_count++;
      $display("BAD %0t got %h exp %h", $time, g, x);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    {psel, pen, pwr, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clk);
    pen <= 1'b1;
    do begin @(posedge clk); end while (pready !== 1'b1);
    {r, e} = {prdata, pslverr};
    {psel, pen, pwdata} <= {2'b00, ~d};
    @(posedge clk);
  endtask : apb
  task automatic core(input cbg_spc_e s, input logic [3:0] be, input logic w,
                      input logic c, input logic [31:0] ad);
    n = 0;
    req <= 1'b1;
    creq <= '{ad, be, w, c, s, 32'h1122_3344};
    do begin @(posedge clk); n++; end while (ack !== 1'b1 && n < 40);
    {ok, rd, er} = {ack === 1'b1, crd, cerr};
    req <= 1'b0;
    creq <= ~creq;
    @(posedge clk);
  endtask : core
  task automatic end_of_test();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test

  initial begin
    #100000;
    bad_count++;
    end_of_test();
  end
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    {rst, req, irq, probe, hit, psel, pen, pwr, slow, err} = 10'b1000100000;
    {paddr, pwdata, creq, warm_seen, sg_seen} = '0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk({stpn, nmi, cken}, 3'b101);
    apb(1'b0, REG_CTRL, 0); chk(r, 32'h10);
    apb(1'b1, REG_CTRL, 32'h3); apb(1'b0, REG_CTRL, 0); chk(r, 32'h7);
    apb(1'b0, 8'h14, 0); chk(e, 1);
    apb(1'b1, REG_DFILL, 32'hd00d_0001); chk(dfill, 32'hd00d_0001);
    apb(1'b1, REG_IFILL, 32'h1ee0_0002); chk(ifill, 32'h1ee0_0002);
    $display("register test done");
    for (int i = 0; i < 10; i++) begin
      c0 = cnt;
      slow <= i[0];
      core(SPC_NONE, wtab[i][15:12], 1'b1, 1'b0, 32'h2000_0000);
      two = wtab[i][11:6] != 6'h0;
      chk(cnt - c0, two ? 2 : 1); chk({ok, er}, 2'b10);
      chk(lg & (two ? 12'hfff : 12'h03f), wtab[i][11:0]);
    end
    chk(burst, 0); chk(wd, 32'h1122_3344);
    $display("write test done");
    core(SPC_NONE, 4'hf, 1'b0, 1'b0, 32'h3000_0008); chk(lg[5:0], 6'h28);
    chk(rd, 32'h3000_0008 ^ 32'h5a5a_a5a5);
    core(SPC_NONE, 4'hf, 1'b0, 1'b1, 32'h0004_0004); chk(lg[5:0], 6'h08);
    c0 = cnt;
    hit <= 1'b0;
    core(SPC_NONE, 4'hf, 1'b0, 1'b0, 32'h7000_0000); chk({rd, cnt}, {32'h0, c0});
    hit <= 1'b1;
    err <= 1'b1;
    core(SPC_NONE, 4'h6, 1'b1, 1'b0, 32'h2000_0000); chk(er, 1);
    err <= 1'b0;
    c0 = cnt;
    core(SPC_NONE, 4'h5, 1'b1, 1'b0, 32'h2000_0000); chk({er, cnt}, {1'b1, c0});
    $display("read and error test done");
    foreach (sp[i]) begin
      core(sp[i], 4'hf, 1'b0, 1'b0, 32'h2000_0000); chk(ok, 1);
    end
    chk(cnt, c0); chk(sg_seen, 1);
    apb(1'b0, REG_CAUSE, 0); chk(r, 32'h2);
    $display("special cycle test done");
    irq <= 1'b1;
    core(SPC_HALT, 4'hf, 1'b0, 1'b0, 0);
    repeat (12) @(posedge clk);
    chk(cken, 1);
    irq <= 1'b0;
    core(SPC_HALT, 4'hf, 1'b0, 1'b0, 0); chk(halt, 1);
    n = 0;
    do begin @(posedge clk); n++; end while (cken === 1'b1 && n < 40);
    chk(n, 7);
    apb(1'b0, REG_STATUS, 0); chk(r, 32'h6);
    probe <= 1'b1;
    repeat (2) @(posedge clk);
    chk({cken, halt}, 2'b10);
    probe <= 1'b0;
    $display("halt test done");
    core(SPC_SHUT, 4'hf, 1'b0, 1'b0, 0); chk({ok, shut, warm_seen}, 3'b111);
    apb(1'b0, REG_CAUSE, 0); chk(r, 32'h3);
    core(SPC_NONE, 4'hf, 1'b0, 1'b0, 32'h3000_0000); chk(ok, 0);
    apb(1'b1, REG_CAUSE, 32'h1); apb(1'b0, REG_CAUSE, 0); chk(r, 32'h2);
    $display("shutdown test done");
    end_of_test();
  end
endmodule : cbg_gasket_tb
`default_nettype wire
